// ==== verilog/opm_pkg.sv ====
// constants shared by the line performance monitor files
// assumes one system clock and a one-second strobe made elsewhere
package opm_pkg;
    localparam int CNT_W = 32;
    localparam int TALLY_W = 24;
    localparam int PATH_SES_K = 2400;
    localparam int FAR_SES_K_DEFAULT = 2400;
    localparam int UAS_RUN = 10;
    localparam int PATH_BIP_MAX = 8;
    localparam int REI_PER_STS = 8;
    localparam int OC48_REI_MAX = 255;
    localparam int STS_N_DEFAULT = 12;
    localparam logic [31:0] CNT_RESET = 32'h0;
    localparam logic [3:0] RUN_RESET = 4'h0;
    typedef enum logic [1:0] {
        OPM_AVAIL = 2'b01,
        OPM_UNAVAIL = 2'b10
    } opm_avail_e;
endpackage

// ==== verilog/opm_unavail.sv ====
// availability tracker: ten-second runs of severe / clean seconds
// assumes tick is a one-cycle strobe already gated by the clock enable
`timescale 1ns/1ps
module opm_unavail (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic ses,
    output logic unavail,
    output logic [4:0] add_secs
);
    opm_pkg::opm_avail_e state;
    opm_pkg::opm_avail_e next_state;
    logic [3:0] run;
    logic [3:0] next_run;
    logic [4:0] next_add;
    logic [3:0] run_inc;

    assign run_inc = run + 4'h1;

    // onset seconds count retroactively; clean run that ends it does not
    always_comb begin
        next_state = state;
        next_run = run;
        next_add = 5'h0;
        if (tick) begin
            case (state)
                opm_pkg::OPM_AVAIL: begin
                    if (!ses) begin
                        next_run = opm_pkg::RUN_RESET;
                    end else if (run_inc == 4'(opm_pkg::UAS_RUN)) begin
                        next_state = opm_pkg::OPM_UNAVAIL;
                        next_run = opm_pkg::RUN_RESET;
                        next_add = 5'(opm_pkg::UAS_RUN);
                    end else begin
                        next_run = run_inc;
                    end
                end
                opm_pkg::OPM_UNAVAIL: begin
                    if (ses) begin
                        // pending clean seconds were unavailable after all
                        next_add = {1'b0, run_inc};
                        next_run = opm_pkg::RUN_RESET;
                    end else if (run_inc == 4'(opm_pkg::UAS_RUN)) begin
                        next_state = opm_pkg::OPM_AVAIL;
                        next_run = opm_pkg::RUN_RESET;
                    end else begin
                        next_run = run_inc;
                    end
                end
                default: begin
                    next_state = opm_pkg::OPM_AVAIL;
                    next_run = opm_pkg::RUN_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= opm_pkg::OPM_AVAIL;
            run <= opm_pkg::RUN_RESET;
            add_secs <= 5'h0;
        end else begin
            state <= next_state;
            run <= next_run;
            add_secs <= next_add;
        end
    end

    assign unavail = (state == opm_pkg::OPM_UNAVAIL);
endmodule

// ==== verilog/opm_monitor.sv ====
// line card performance counters: protection, path and far-end line
// assumes all inputs are synchronous to clock; second_tick is one cycle
`timescale 1ns/1ps
// Functional notes
// - ring protect span count rises on switch onto it and on return
// - working 1+1 card counts switches to protection and back
// - protection 1+1 card counts switches to working and back
// - 1+1 count held at zero and invalid unless revertive switching
// - ring protect duration adds a second while carrying working traffic
// - ring working line counts switches away and back after failure
// - ring working duration adds a second while carried on protection
// - path counters frozen unless intermediate path monitoring enabled
// - path code violations add every B3 parity error, up to eight a frame
// - path errored second on any parity error or AIS-P / LOP-P
// - path severe second at 2400 errors or AIS-P / LOP-P
// - path failure event starts on AIS, LOP, UNEQ, TIM or supported RDI
// - path unavailable from ten severe seconds until ten clean ones
// - ten clean seconds ending unavailability are not counted
// - far line violations add REI-L count, clamped to 8xN or 255
// - far line errored second on any reported error or RDI-L
// - far line severe second at threshold errors or RDI-L
// - far line unavailability by ten-second runs, closing ten clean seconds not counted
// - far line failure event counted once at RFI-L onset
module opm_monitor #(
    parameter int STS_N = opm_pkg::STS_N_DEFAULT,
    parameter int FAR_SES_K = opm_pkg::FAR_SES_K_DEFAULT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic second_tick,
    input wire logic path_monitor_enable,
    input wire logic path_bip_valid,
    input wire logic [3:0] path_bip_count,
    input wire logic ais_p,
    input wire logic lop_p,
    input wire logic uneq_p,
    input wire logic tim_p,
    input wire logic rdi_p,
    input wire logic rdi_p_supported,
    input wire logic far_rei_valid,
    input wire logic [7:0] far_rei_count,
    input wire logic line_rate_oc48,
    input wire logic rdi_l,
    input wire logic rfi_l,
    input wire logic ring_switch_onto,
    input wire logic ring_switch_return,
    input wire logic ring_protect_active,
    input wire logic ring_working_away,
    input wire logic ring_working_back,
    input wire logic ring_working_on_protect,
    input wire logic oneplus_is_protect_card,
    input wire logic oneplus_revertive,
    input wire logic oneplus_switch_away,
    input wire logic oneplus_switch_back,
    output logic [31:0] protection_switch_count,
    output logic [31:0] protection_switch_duration,
    output logic [31:0] working_switch_count,
    output logic [31:0] working_switch_duration,
    output logic [31:0] oneplus_switch_count,
    output logic oneplus_count_valid,
    output logic [31:0] path_code_violations,
    output logic [31:0] path_errored_seconds,
    output logic [31:0] path_severe_errored_seconds,
    output logic [31:0] path_failure_events,
    output logic [31:0] path_unavailable_seconds,
    output logic path_unavailable,
    output logic [31:0] far_line_code_violations,
    output logic [31:0] far_line_errored_seconds,
    output logic [31:0] far_line_severe_seconds,
    output logic [31:0] far_line_unavailable_seconds,
    output logic [31:0] far_line_failure_events,
    output logic far_line_unavailable
);
    localparam int CW = opm_pkg::CNT_W;
    localparam int TW = opm_pkg::TALLY_W;

    if (STS_N < 1 || STS_N * opm_pkg::REI_PER_STS > opm_pkg::OC48_REI_MAX)
    begin : g_bad_sts
        $error("STS_N out of range for an 8-bit REI count");
    end
    if (FAR_SES_K < 1 || FAR_SES_K >= (1 << TW)) begin : g_bad_k
        $error("FAR_SES_K out of tally range");
    end

    // counters saturate rather than wrap so a stuck fault stays visible
    function automatic logic [CW-1:0] sat_add(input logic [CW-1:0] a,
                                              input logic [CW-1:0] b);
        logic [CW:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[CW] ? {CW{1'b1}} : s[CW-1:0];
    endfunction

    function automatic logic [TW-1:0] tally_add(input logic [TW-1:0] a,
                                                input logic [7:0] b);
        logic [TW:0] s;
        s = {1'b0, a} + {{(TW - 7){1'b0}}, b};
        return s[TW] ? {TW{1'b1}} : s[TW-1:0];
    endfunction

    function automatic logic [CW-1:0] widen(input logic [7:0] v);
        return {{(CW - 8){1'b0}}, v};
    endfunction

    // qualified strobes and events
    wire tick = clk_en && second_tick;
    wire path_on = clk_en && path_monitor_enable;
    wire path_tick = path_on && second_tick;
    wire [3:0] bip_clip = (path_bip_count > 4'(opm_pkg::PATH_BIP_MAX)) ?
        4'(opm_pkg::PATH_BIP_MAX) : path_bip_count;
    wire [7:0] path_add = path_bip_valid ? {4'h0, bip_clip} : 8'h00;
    wire [7:0] rei_limit = line_rate_oc48 ? 8'(opm_pkg::OC48_REI_MAX) :
        8'(STS_N * opm_pkg::REI_PER_STS);
    wire [7:0] rei_clip = (far_rei_count > rei_limit) ? rei_limit :
        far_rei_count;
    wire [7:0] far_add = far_rei_valid ? rei_clip : 8'h00;

    // second tallies and defect-seen flags
    logic [TW-1:0] path_tally;
    logic [TW-1:0] far_tally;
    logic path_def_seen;
    logic rdi_l_seen;
    wire [TW-1:0] path_sum = tally_add(path_tally, path_add);
    wire [TW-1:0] far_sum = tally_add(far_tally, far_add);
    wire path_def = ais_p || lop_p;
    wire path_es = (path_sum != '0) || path_def_seen || path_def;
    wire path_ses = (path_sum >= TW'(opm_pkg::PATH_SES_K)) ||
        path_def_seen || path_def;
    wire far_es = (far_sum != '0) || rdi_l_seen || rdi_l;
    wire far_ses = (far_sum >= TW'(FAR_SES_K)) || rdi_l_seen ||
        rdi_l;

    // failure onset detection
    wire path_fail = ais_p || lop_p || uneq_p || tim_p ||
        (rdi_p && rdi_p_supported);
    logic path_fail_prev;
    logic rfi_prev;
    wire path_fail_onset = path_fail && !path_fail_prev;
    wire rfi_onset = rfi_l && !rfi_prev;

    // protection event amounts, two events in one cycle both count
    wire [7:0] ring_sw = {7'h0, ring_switch_onto} +
        {7'h0, ring_switch_return};
    wire [7:0] work_sw = {7'h0, ring_working_away} +
        {7'h0, ring_working_back};
    // card role only names the direction; both roles count away and back
    wire [7:0] one_sw = {7'h0, oneplus_switch_away} +
        {7'h0, oneplus_switch_back};

    logic [4:0] path_uas_add;
    logic [4:0] far_uas_add;

    opm_unavail u_path_unavail (
        .clock(clock),
        .rst_n(rst_n),
        .tick(path_tick),
        .ses(path_ses),
        .unavail(path_unavailable),
        .add_secs(path_uas_add)
    );

    opm_unavail u_far_unavail (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick),
        .ses(far_ses),
        .unavail(far_line_unavailable),
        .add_secs(far_uas_add)
    );

    // tallies restart with the current cycle's errors, so none are lost
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            path_tally <= '0;
            path_def_seen <= 1'b0;
            path_fail_prev <= 1'b0;
        end else if (path_on) begin
            path_tally <= second_tick ? TW'(path_add) : path_sum;
            path_def_seen <= second_tick ? path_def :
                (path_def_seen || path_def);
            path_fail_prev <= path_fail;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            far_tally <= '0;
            rdi_l_seen <= 1'b0;
            rfi_prev <= 1'b0;
        end else if (clk_en) begin
            far_tally <= second_tick ? TW'(far_add) : far_sum;
            rdi_l_seen <= second_tick ? rdi_l : (rdi_l_seen || rdi_l);
            rfi_prev <= rfi_l;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            path_code_violations <= opm_pkg::CNT_RESET;
            path_errored_seconds <= opm_pkg::CNT_RESET;
            path_severe_errored_seconds <= opm_pkg::CNT_RESET;
            path_failure_events <= opm_pkg::CNT_RESET;
            path_unavailable_seconds <= opm_pkg::CNT_RESET;
        end else if (path_on) begin
            path_code_violations <= sat_add(path_code_violations,
                widen(path_add));
            path_errored_seconds <= sat_add(path_errored_seconds,
                widen({7'h0, second_tick && path_es}));
            path_severe_errored_seconds <= sat_add(
                path_severe_errored_seconds,
                widen({7'h0, second_tick && path_ses}));
            path_failure_events <= sat_add(path_failure_events,
                widen({7'h0, path_fail_onset}));
            path_unavailable_seconds <= sat_add(path_unavailable_seconds,
                widen({3'h0, path_uas_add}));
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            far_line_code_violations <= opm_pkg::CNT_RESET;
            far_line_errored_seconds <= opm_pkg::CNT_RESET;
            far_line_severe_seconds <= opm_pkg::CNT_RESET;
            far_line_unavailable_seconds <= opm_pkg::CNT_RESET;
            far_line_failure_events <= opm_pkg::CNT_RESET;
        end else if (clk_en) begin
            far_line_code_violations <= sat_add(far_line_code_violations,
                widen(far_add));
            far_line_errored_seconds <= sat_add(far_line_errored_seconds,
                widen({7'h0, second_tick && far_es}));
            far_line_severe_seconds <= sat_add(far_line_severe_seconds,
                widen({7'h0, second_tick && far_ses}));
            far_line_unavailable_seconds <= sat_add(
                far_line_unavailable_seconds, widen({3'h0, far_uas_add}));
            far_line_failure_events <= sat_add(far_line_failure_events,
                widen({7'h0, rfi_onset}));
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            protection_switch_count <= opm_pkg::CNT_RESET;
            protection_switch_duration <= opm_pkg::CNT_RESET;
            working_switch_count <= opm_pkg::CNT_RESET;
            working_switch_duration <= opm_pkg::CNT_RESET;
            oneplus_switch_count <= opm_pkg::CNT_RESET;
        end else if (clk_en) begin
            protection_switch_count <= sat_add(protection_switch_count,
                widen(ring_sw));
            protection_switch_duration <= sat_add(
                protection_switch_duration,
                widen({7'h0, second_tick && ring_protect_active}));
            working_switch_count <= sat_add(working_switch_count,
                widen(work_sw));
            working_switch_duration <= sat_add(working_switch_duration,
                widen({7'h0, second_tick && ring_working_on_protect}));
            // non-revertive: count has no meaning, held cleared
            oneplus_switch_count <= oneplus_revertive ?
                sat_add(oneplus_switch_count, widen(one_sw)) :
                opm_pkg::CNT_RESET;
        end
    end

    assign oneplus_count_valid = oneplus_revertive;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_path_second;
        clk_en && path_monitor_enable && second_tick;
    endsequence

    // counted run of severe seconds, too long for a repetition operator
    logic [3:0] ses_run_seen;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ses_run_seen <= 4'h0;
        end else if (path_tick) begin
            ses_run_seen <= (path_ses && !path_unavailable) ?
                ses_run_seen + 4'h1 : 4'h0;
        end
    end

    ring_count_a: assert property (clk_en && ring_switch_onto &&
        ring_switch_return |=> protection_switch_count ==
        $past(protection_switch_count) + 32'h2)
        else $error("protect span switches not both counted");

    oneplus_count_a: assert property (clk_en &&
        oneplus_revertive && !oneplus_is_protect_card &&
        oneplus_switch_away && !oneplus_switch_back |=>
        oneplus_switch_count == $past(oneplus_switch_count) + 32'h1)
        else $error("1+1 working card switch not counted");

    oneplus_role_a: assert property (clk_en &&
        oneplus_revertive && oneplus_is_protect_card &&
        oneplus_switch_back && !oneplus_switch_away |=>
        oneplus_switch_count == $past(oneplus_switch_count) + 32'h1)
        else $error("1+1 protection card switch not counted");

    oneplus_nonrev_a: assert property (clk_en &&
        !oneplus_revertive |=> oneplus_switch_count == 32'h0 &&
        !$past(oneplus_count_valid))
        else $error("1+1 count live while non-revertive");

    work_duration_a: assert property (tick &&
        ring_working_on_protect |=> working_switch_duration ==
        $past(working_switch_duration) + 32'h1)
        else $error("working duration missed a second");

    path_freeze_a: assert property (!clk_en ||
        !path_monitor_enable |=> $stable(path_code_violations) &&
        $stable(path_errored_seconds) && $stable(path_failure_events))
        else $error("path counter moved while monitoring off");

    path_cv_a: assert property (clk_en && path_monitor_enable &&
        path_bip_valid && path_bip_count <= 4'h8 |=> path_code_violations
        == $past(path_code_violations) + 32'($past(path_bip_count)))
        else $error("path violations not added");

    path_defect_a: assert property (s_path_second ##0
        (ais_p || lop_p || path_def_seen) |=>
        path_severe_errored_seconds ==
        $past(path_severe_errored_seconds) + 32'h1 &&
        path_errored_seconds == $past(path_errored_seconds) + 32'h1)
        else $error("defect second not severe");

    path_fail_a: assert property (clk_en && path_monitor_enable &&
        $rose(path_fail) ##0 $past(clk_en && path_monitor_enable)
        |=> path_failure_events == $past(path_failure_events) + 32'h1)
        else $error("path failure onset not counted");

    path_uas_a: assert property (s_path_second ##0 (path_ses &&
        !path_unavailable && ses_run_seen == 4'(opm_pkg::UAS_RUN - 1))
        |=> path_unavailable)
        else $error("ten severe seconds did not make path unavailable");

    far_clamp_a: assert property (clk_en && far_rei_valid
        |=> far_line_code_violations - $past(far_line_code_violations)
        <= ($past(line_rate_oc48) ? 32'hff : 32'(STS_N * 8)))
        else $error("far violations exceed frame limit");

    far_fail_a: assert property (clk_en && rfi_l && !rfi_prev
        ##1 clk_en && rfi_l |-> far_line_failure_events ==
        $past(far_line_failure_events) + 32'h1 ##1
        far_line_failure_events == $past(far_line_failure_events))
        else $error("far failure event counted twice");

    tally_clear_a: assert property (tick && !far_rei_valid |=>
        far_tally == '0)
        else $error("far tally not cleared at second");
endmodule

// ==== test/opm_far_end.sv ====
// far-end line terminating equipment model: REI-L counts, RDI-L, RFI-L
// assumes the bench calls its tasks from the monitor's clock domain
`timescale 1ns/1ps
module opm_far_end (
    input wire logic clock,
    output logic far_rei_valid,
    output logic [7:0] far_rei_count,
    output logic rdi_l,
    output logic rfi_l
);
    initial begin
        far_rei_valid = 1'b0;
        far_rei_count = 8'h00;
        rdi_l = 1'b0;
        rfi_l = 1'b0;
    end
    // count flips after the frame so a stale value never reads as valid
    task automatic send_rei(input logic [7:0] n);
        @(posedge clock) far_rei_valid <= 1'b1;
        far_rei_count <= n;
        @(posedge clock) far_rei_valid <= 1'b0;
        far_rei_count <= ~n;
    endtask
    task automatic set_rdi(input logic v);
        @(posedge clock) rdi_l <= v;
    endtask
    task automatic set_rfi(input logic v);
        @(posedge clock) rfi_l <= v;
    endtask
endmodule

// ==== test/test_opm_monitor.sv ====
// self-checking bench for the line performance monitor
// assumes the far-end model drives the REI-L and line defect inputs
`timescale 1ns/1ps
module test_opm_monitor;
    localparam int STS_N = 12;
    // small far threshold keeps severe far seconds cheap to reach
    localparam int FK = 100;
    logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, second_tick = 1'b0;
    logic path_monitor_enable = 1'b1, path_bip_valid = 1'b0;
    logic [3:0] path_bip_count = 4'h0;
    logic ais_p = 1'b0, lop_p = 1'b0, uneq_p = 1'b0, tim_p = 1'b0;
    logic rdi_p = 1'b0, rdi_p_supported = 1'b0, line_rate_oc48 = 1'b0;
    logic ring_switch_onto = 1'b0, ring_switch_return = 1'b0;
    logic ring_protect_active = 1'b0, ring_working_away = 1'b0;
    logic ring_working_back = 1'b0, ring_working_on_protect = 1'b0;
    logic oneplus_is_protect_card = 1'b0, oneplus_revertive = 1'b0;
    logic oneplus_switch_away = 1'b0, oneplus_switch_back = 1'b0;
    logic far_rei_valid, rdi_l, rfi_l;
    logic [7:0] far_rei_count;
    logic [31:0] protection_switch_count, protection_switch_duration;
    logic [31:0] working_switch_count, working_switch_duration;
    logic [31:0] oneplus_switch_count, path_code_violations;
    logic [31:0] path_errored_seconds, path_severe_errored_seconds;
    logic [31:0] path_failure_events, path_unavailable_seconds;
    logic [31:0] far_line_code_violations, far_line_errored_seconds;
    logic [31:0] far_line_severe_seconds, far_line_unavailable_seconds;
    logic [31:0] far_line_failure_events;
    logic oneplus_count_valid, path_unavailable, far_line_unavailable;
    int bad_count = 0, cmp_count = 0;
    int e_cv = 0, e_es = 0, e_ses = 0, e_fc = 0, e_uas = 0, pt = 0;
    int e_fcv = 0, e_fes = 0, e_fses = 0, e_ffc = 0, e_fuas = 0, ft = 0;
    int e_psc = 0, e_psd = 0, e_wsc = 0, e_wsd = 0, e_ops = 0;
    int prun = 0, pcln = 0, frun = 0, fcln = 0;
    bit p_un = 1'b0, f_un = 1'b0;

    opm_monitor #(.STS_N(STS_N), .FAR_SES_K(FK)) DUT (.*);
    opm_far_end FAR (.*);

    initial begin
        forever #20 clock = ~clock;
    end

    task automatic test_done();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic chk_all();
        repeat (2) @(posedge clock);
        #1;
        chk("cv", path_code_violations, e_cv);
        chk("es", path_errored_seconds, e_es);
        chk("ses", path_severe_errored_seconds, e_ses);
        chk("fc", path_failure_events, e_fc);
        chk("uas", path_unavailable_seconds, e_uas);
        chk("unav", {31'h0, path_unavailable}, {31'h0, p_un});
        chk("fcv", far_line_code_violations, e_fcv);
        chk("fes", far_line_errored_seconds, e_fes);
        chk("fses", far_line_severe_seconds, e_fses);
        chk("fuas", far_line_unavailable_seconds, e_fuas);
        chk("fun", {31'h0, far_line_unavailable}, {31'h0, f_un});
        chk("ffc", far_line_failure_events, e_ffc);
        chk("psc", protection_switch_count, e_psc);
        chk("psd", protection_switch_duration, e_psd);
        chk("wsc", working_switch_count, e_wsc);
        chk("wsd", working_switch_duration, e_wsd);
        chk("ops", oneplus_switch_count, e_ops);
        chk("opv", {31'h0, oneplus_count_valid},
            {31'h0, oneplus_revertive});
    endtask

    // runs of ten severe or clean seconds; clean run dropped on exit
    task automatic track(input bit s, inout int run, inout int cln,
                         inout bit un, inout int uas);
        if (!un) begin
            run = s ? run + 1 : 0;
            if (run == opm_pkg::UAS_RUN) begin
                un = 1'b1;
                uas += opm_pkg::UAS_RUN;
                run = 0;
                cln = 0;
            end
        end else if (s) begin
            uas += 1 + cln;
            cln = 0;
        end else begin
            cln++;
            if (cln == opm_pkg::UAS_RUN) begin
                un = 1'b0;
                cln = 0;
            end
        end
    endtask

    task automatic bip(input logic [3:0] n);
        @(posedge clock) path_bip_valid <= 1'b1;
        path_bip_count <= n;
        @(posedge clock) path_bip_valid <= 1'b0;
        if (clk_en && path_monitor_enable) begin
            e_cv += (n > 8) ? 8 : n;
            pt += (n > 8) ? 8 : n;
        end
    endtask

    task automatic rei(input logic [7:0] n);
        int lim;
        FAR.send_rei(n);
        lim = line_rate_oc48 ? opm_pkg::OC48_REI_MAX
                             : opm_pkg::REI_PER_STS * STS_N;
        e_fcv += (n > lim) ? lim : n;
        ft += (n > lim) ? lim : n;
    endtask

    // defects sit in one cycle inside the second, never on the tick
    task automatic sec(input logic ais, input logic lop, input logic rdi);
        bit ps;
        bit fs;
        FAR.set_rdi(rdi);
        ais_p <= ais;
        lop_p <= lop;
        FAR.set_rdi(1'b0);
        ais_p <= 1'b0;
        lop_p <= 1'b0;
        second_tick <= 1'b1;
        @(posedge clock) second_tick <= 1'b0;
        ps = ais | lop | (pt >= opm_pkg::PATH_SES_K);
        fs = rdi | (ft >= FK);
        if (path_monitor_enable) begin
            e_es += (ais | lop | (pt != 0));
            e_ses += ps;
            e_fc += (ais | lop);
            track(ps, prun, pcln, p_un, e_uas);
            pt = 0;
        end
        e_fes += (rdi | (ft != 0));
        e_fses += fs;
        track(fs, frun, fcln, f_un, e_fuas);
        ft = 0;
        e_psd += ring_protect_active;
        e_wsd += ring_working_on_protect;
    endtask

    task automatic op_pair();
        @(posedge clock) oneplus_switch_away <= 1'b1;
        @(posedge clock) oneplus_switch_away <= 1'b0;
        oneplus_switch_back <= 1'b1;
        @(posedge clock) oneplus_switch_back <= 1'b0;
        e_ops = oneplus_revertive ? e_ops + 2 : 0;
    endtask

    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        chk_all();
        bip(4'h3);
        bip(4'h9);
        @(posedge clock) clk_en <= 1'b0;
        bip(4'h5);
        clk_en <= 1'b1;
        @(posedge clock) path_monitor_enable <= 1'b0;
        bip(4'h5);
        sec(1'b0, 1'b1, 1'b0);
        path_monitor_enable <= 1'b1;
        chk_all();
        chk("frozen", path_errored_seconds, e_es);
        sec(1'b0, 1'b0, 1'b0);
        repeat (299) bip(4'h8);
        bip(4'h7);
        sec(1'b0, 1'b0, 1'b0);
        bip(4'h1);
        sec(1'b0, 1'b0, 1'b0);
        chk_all();
        chk("clear", path_severe_errored_seconds, e_ses);
        repeat (300) bip(4'h8);
        sec(1'b0, 1'b0, 1'b0);
        sec(1'b1, 1'b0, 1'b0);
        repeat (10) sec(1'b0, 1'b1, 1'b0);
        chk_all();
        repeat (5) sec(1'b0, 1'b0, 1'b0);
        sec(1'b0, 1'b1, 1'b0);
        repeat (10) sec(1'b0, 1'b0, 1'b0);
        chk_all();
        for (int i = 0; i < 4; i++) begin
            @(posedge clock) uneq_p <= (i == 0);
            tim_p <= (i == 1);
            rdi_p <= (i >= 2);
            rdi_p_supported <= (i == 3);
            repeat (3) @(posedge clock);
            {uneq_p, tim_p, rdi_p} <= 3'h0;
            e_fc += (i != 2);
        end
        chk_all();
        rei(8'hc8);
        rei(8'h03);
        sec(1'b0, 1'b0, 1'b0);
        rei(8'h60);
        rei(8'h04);
        sec(1'b0, 1'b0, 1'b0);
        @(posedge clock) line_rate_oc48 <= 1'b1;
        rei(8'hff);
        sec(1'b0, 1'b0, 1'b1);
        chk_all();
        repeat (10) sec(1'b0, 1'b0, 1'b1);
        chk_all();
        repeat (10) sec(1'b0, 1'b0, 1'b0);
        FAR.set_rfi(1'b1);
        e_ffc++;
        repeat (2) sec(1'b0, 1'b0, 1'b0);
        FAR.set_rfi(1'b0);
        chk_all();
        @(posedge clock) {ring_switch_onto, ring_switch_return} <= 2'h3;
        ring_working_away <= 1'b1;
        @(posedge clock) {ring_switch_onto, ring_switch_return} <= 2'h0;
        ring_working_away <= 1'b0;
        ring_working_back <= 1'b1;
        @(posedge clock) ring_working_back <= 1'b0;
        e_psc += 2;
        e_wsc += 2;
        ring_protect_active <= 1'b1;
        ring_working_on_protect <= 1'b1;
        repeat (3) sec(1'b0, 1'b0, 1'b0);
        op_pair();
        chk_all();
        @(posedge clock) oneplus_revertive <= 1'b1;
        op_pair();
        @(posedge clock) oneplus_is_protect_card <= 1'b1;
        op_pair();
        chk_all();
        chk("role", oneplus_switch_count, 32'h4);
        @(posedge clock) oneplus_revertive <= 1'b0;
        e_ops = 0;
        chk_all();
        test_done();
    end

    // hang guard, well above the longest run of the sequence
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        test_done();
    end
endmodule
